/* File: rtl/crc_pkg.sv */
package crc_pkg;
    // data path widths
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int FIELD_W = 5;
    localparam int CNT_W = 5;
    localparam int FIFO_MAX = 16;
    // word width field thresholds for fifo depth
    localparam logic [4:0] WIDE_MIN = 5'h10;
    localparam logic [4:0] MID_MIN = 5'h08;
    // fifo depth per width band
    localparam logic [4:0] DEPTH_WIDE = 5'h04;
    localparam logic [4:0] DEPTH_MID = 5'h08;
    localparam logic [4:0] DEPTH_NARROW = 5'h10;
    // word counts with meaning
    localparam logic [4:0] ONE_WORD = 5'h01;
    localparam logic [4:0] NO_WORDS = 5'h00;
    // shift engine stepping
    localparam logic [5:0] BITS_PER_STEP = 6'h02;
    localparam logic [5:0] ONE_BIT = 6'h01;
    localparam logic [5:0] IDX_START = 6'h00;
    // reset values
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // shift engine states
    typedef enum logic [0:0] {
        ENG_IDLE  = 1'b0,
        ENG_SHIFT = 1'b1
    } eng_state_e;
endpackage

/* File: rtl/crc_word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module crc_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int CNT_W = 5
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // control
    input  wire logic             flush,
    input  wire logic [CNT_W-1:0] limit,
    // filling side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // draining side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady,
    // state
    output logic [CNT_W-1:0]      count,
    output logic                  full,
    output logic                  empty
);
    localparam int PTR_W = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth
    if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < 2 || (1 << CNT_W) <= DEPTH)
    begin : g_bad_depth
        $error("crc_word_fifo: depth must be a power of two that fits the count");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];   // word storage
    logic [PTR_W-1:0] wrPtr_q;         // next write slot
    logic [PTR_W-1:0] rdPtr_q;         // oldest word
    logic [CNT_W-1:0] count_q;         // valid words
    logic [CNT_W-1:0] count_d;
    logic             full_q;
    logic             empty_q;
    logic             push;
    logic             pop;

    // handshake terms; full refuses writes until a word drains
    assign push = inValid & ~full_q & ~flush;
    assign pop = outReady & ~empty_q & ~flush;
    assign inReady = ~full_q;
    assign outValid = ~empty_q;
    assign outData = mem_q[rdPtr_q];
    assign count = count_q;
    assign full = full_q;
    assign empty = empty_q;
    // a shrinking limit still reads full, hence the compare
    assign count_d = flush ? '0 : CNT_W'(count_q + CNT_W'(push) - CNT_W'(pop));

    // storage has no reset; pointers, count and flags do
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    // pointers, count and flags
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end
        else
        begin
            wrPtr_q <= flush ? '0 : PTR_W'(wrPtr_q + PTR_W'(push));
            rdPtr_q <= flush ? '0 : PTR_W'(rdPtr_q + PTR_W'(pop));
            count_q <= count_d;
            full_q <= (count_d >= limit);
            empty_q <= (count_d == '0);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/programmable_crc_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module programmable_crc_engine
    import crc_pkg::*;
(
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    // configuration levels
    input  wire logic               moduleEnable,
    input  wire logic               lsbFirstSelect,
    input  wire logic               irqSourceSelect,
    input  wire logic [FIELD_W-1:0] polyLenField,
    input  wire logic [FIELD_W-1:0] wordWidthField,
    input  wire logic [HALF_W-1:0]  polyTermsLow,
    input  wire logic [HALF_W-1:0]  polyTermsHigh,
    // data input half writes
    input  wire logic               dataWrite,
    input  wire logic               dataHighHalf,
    input  wire logic [1:0]         dataByteEn,
    input  wire logic [HALF_W-1:0]  dataWdata,
    // go bit strobes
    input  wire logic               goSet,
    input  wire logic               goClear,
    // result preload
    input  wire logic               resultWrite,
    input  wire logic [DATA_W-1:0]  resultWdata,
    // status
    output logic                    shiftGo,
    output logic [CNT_W-1:0]        validWordCount,
    output logic                    fifoFullFlag,
    output logic                    fifoEmptyFlag,
    output logic [DATA_W-1:0]       resultPair,
    output logic                    crcIrq
);
    // one feedback step; bit zero of taps is the constant term
    function automatic logic [DATA_W-1:0] crc_step(
        input logic [DATA_W-1:0]  cur,
        input logic               din,
        input logic [DATA_W-1:0]  tapSel,
        input logic [FIELD_W-1:0] topIdx
    );
        logic fb;
        fb = cur[topIdx] ^ din;
        return (cur << 1) ^ ({DATA_W{fb}} & tapSel);
    endfunction

    // configuration decode
    logic [DATA_W-1:0] widthMask;      // bits inside the word width
    logic [DATA_W-1:0] polyMask;       // bits inside the polynomial
    logic [DATA_W-1:0] taps;           // effective feedback taps
    logic [CNT_W-1:0]  fifoLimit;      // depth for the current width
    logic [5:0]        width6;         // word width in bits

    // word assembly and fifo hookup
    logic [DATA_W-1:0] asm_q;          // bytes written so far
    logic [DATA_W-1:0] asm_d;
    logic              wordDone;       // write carried the msb byte
    logic              pushValid;
    logic              pushReady;
    logic              pushAccepted;
    logic [DATA_W-1:0] pushData;
    logic              popReady;
    logic              fifoOutValid;
    logic [DATA_W-1:0] fifoOutData;
    logic              pop;

    // shift engine
    eng_state_e        state_q;
    eng_state_e        state_d;
    logic [DATA_W-1:0] buf_q;          // word being shifted
    logic [5:0]        bitIdx_q;       // bits already consumed
    logic [5:0]        remain;
    logic [5:0]        pos0;
    logic [5:0]        pos1;
    logic              twoBits;
    logic              shiftActive;
    logic              lastStep;
    logic [DATA_W-1:0] crcOne;
    logic [DATA_W-1:0] crcTwo;
    logic [DATA_W-1:0] crc_q;          // live checksum
    logic [DATA_W-1:0] crc_d;
    logic              go_q;
    logic              go_d;
    logic              started_q;      // a word was taken since go
    logic              finishNow;
    logic              hwDone;
    logic              emptyEvt;
    logic              crcIrq_q;

    // only bits up to the order take part
    assign polyMask = ~((({DATA_W{1'b1}}) << polyLenField) << 1);
    // constant term forced, stored bit zero unused
    // top term is the feedback source, not a tap
    assign taps = {polyTermsHigh, polyTermsLow[HALF_W-1:1], 1'b1} & polyMask;

    // word width mask from width field
    assign widthMask = ~((({DATA_W{1'b1}}) << wordWidthField) << 1);
    assign width6 = {1'b0, wordWidthField} + ONE_BIT;

    assign fifoLimit = (wordWidthField >= WIDE_MIN) ? DEPTH_WIDE :
                       (wordWidthField >= MID_MIN)  ? DEPTH_MID  : DEPTH_NARROW;

    // merge written bytes into the pending word
    always_comb
    begin
        asm_d = asm_q;
        for (int lane = 0; lane < 2; lane++)
        begin
            if (dataWrite && dataByteEn[lane])
            begin
                asm_d[(32'(dataHighHalf) * HALF_W) + (lane * BYTE_W) +: BYTE_W] =
                    dataWdata[lane * BYTE_W +: BYTE_W];
            end
        end
    end

    // word counted when the msb byte lane is written
    // relies on low half written before high half
    assign wordDone = dataWrite & (dataHighHalf == wordWidthField[4]) & dataByteEn[wordWidthField[3]];
    assign pushValid = wordDone & moduleEnable;
    // bits above the width never reach the engine
    assign pushData = asm_d & widthMask;
    assign pushAccepted = pushValid & pushReady;

    // words drain only while go is set
    assign popReady = go_q & moduleEnable & ((state_q == ENG_IDLE) | lastStep);
    assign pop = popReady & fifoOutValid;

    // full and empty flags come from the fifo count
    // disable flushes the fifo and zeroes the count
    crc_word_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_MAX),
        .CNT_W (CNT_W)
    ) u_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .flush    (~moduleEnable),
        .limit    (fifoLimit),
        .inValid  (pushValid),
        .inData   (pushData),
        .inReady  (pushReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (popReady),
        .count    (validWordCount),
        .full     (fifoFullFlag),
        .empty    (fifoEmptyFlag)
    );

    // two bits per cycle, one on an odd tail
    assign shiftActive = (state_q == ENG_SHIFT) & go_q & moduleEnable;
    assign remain = width6 - bitIdx_q;
    assign twoBits = remain >= BITS_PER_STEP;
    assign lastStep = shiftActive & (remain <= BITS_PER_STEP);

    // bit order into the engine; result never reflected
    assign pos0 = lsbFirstSelect ? bitIdx_q : width6 - ONE_BIT - bitIdx_q;
    assign pos1 = lsbFirstSelect ? bitIdx_q + ONE_BIT : width6 - BITS_PER_STEP - bitIdx_q;
    assign crcOne = crc_step(crc_q, buf_q[pos0[4:0]], taps, polyLenField) & polyMask;
    assign crcTwo = crc_step(crcOne, buf_q[pos1[4:0]], taps, polyLenField) & polyMask;

    // completion once the fifo is dry after real work
    assign finishNow = go_q & moduleEnable & started_q & ~fifoOutValid & ((state_q == ENG_IDLE) | lastStep);
    // a same-cycle software strobe takes over and suppresses the event
    assign hwDone = finishNow & ~goClear & ~goSet;
    assign emptyEvt = pop & ~pushAccepted & (validWordCount == ONE_WORD);

    // engine next state
    always_comb
    begin
        state_d = state_q;
        if (!moduleEnable)
        begin
            state_d = ENG_IDLE;
        end
        else if (pop)
        begin
            state_d = ENG_SHIFT;
        end
        else if (lastStep)
        begin
            state_d = ENG_IDLE;
        end
    end

    // preload wins over shifting; zero starts, keep resumes
    // last bit or pair of bits lands with the completion edge
    assign crc_d = !moduleEnable ? RESULT_RESET :
                   resultWrite   ? (resultWdata & polyMask) :
                   shiftActive   ? (twoBits ? crcTwo : crcOne) : crc_q;

    // go self clears; set strobe beats both clears
    assign go_d = !moduleEnable ? 1'b0 :
                  goSet         ? 1'b1 :
                  (goClear | finishNow) ? 1'b0 : go_q;

    // engine registers
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ENG_IDLE;
            bitIdx_q <= IDX_START;
            buf_q <= WORD_RESET;
        end
        else
        begin
            state_q <= state_d;
            if (pop)
            begin
                buf_q <= fifoOutData;
                bitIdx_q <= IDX_START;
            end
            else if (shiftActive)
            begin
                bitIdx_q <= bitIdx_q + BITS_PER_STEP;
            end
        end
    end

    // pending word is cleared when the module is off
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            asm_q <= WORD_RESET;
        end
        else
        begin
            asm_q <= moduleEnable ? asm_d : WORD_RESET;
        end
    end

    // checksum, go bit and event pulse
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_q <= RESULT_RESET;
            go_q <= 1'b0;
            started_q <= 1'b0;
            crcIrq_q <= 1'b0;
        end
        else
        begin
            crc_q <= crc_d;
            go_q <= go_d;
            crcIrq_q <= moduleEnable & (irqSourceSelect ? hwDone : emptyEvt);
            if (goSet || !go_d)
            begin
                started_q <= 1'b0;
            end
            else if (pop)
            begin
                started_q <= 1'b1;
            end
        end
    end

    assign shiftGo = go_q;
    assign resultPair = crc_q;
    assign crcIrq = crcIrq_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    chk_pop_needs_go: assert property (pop |-> go_q && validWordCount != NO_WORDS)
        else $error("word taken without go or words");
    chk_two_bits: assert property (shiftActive && !lastStep |=> bitIdx_q == $past(bitIdx_q) + BITS_PER_STEP)
        else $error("engine did not advance two bits");
    chk_disable_flush: assert property (!moduleEnable |=> validWordCount == NO_WORDS && !shiftGo)
        else $error("disabled module kept words or go");
    chk_full_flag: assert property (validWordCount == $past(fifoLimit) |-> fifoFullFlag)
        else $error("full flag missing at depth");
    chk_empty_flag: assert property (validWordCount == NO_WORDS |-> fifoEmptyFlag && !fifoFullFlag)
        else $error("empty flag wrong at zero");
    chk_count_rise: assert property (pushAccepted && !pop |=> validWordCount == $past(validWordCount) + ONE_WORD)
        else $error("count did not rise on msb byte");
    chk_count_hold: assert property (dataWrite && !wordDone && !pop && moduleEnable |=> $stable(validWordCount))
        else $error("count moved on a non-msb write");
    chk_soft_clear: assert property (goClear && irqSourceSelect |=> !crcIrq)
        else $error("software clear raised an event");
    chk_empty_irq: assert property (emptyEvt && !irqSourceSelect && moduleEnable |=> crcIrq)
        else $error("no event when count emptied");
    chk_done_clears: assert property (hwDone |=> !shiftGo && crcIrq == $past(irqSourceSelect))
        else $error("completion did not clear go or signal");
    chk_poly_width: assert property (shiftActive && !resultWrite |=> (resultPair & ~$past(polyMask)) == '0)
        else $error("checksum bits above the order");
endmodule
`default_nettype wire

/* File: sim/crc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// processor core side: drives half writes, go strobes and result preloads
module crc_core_model
(
    // clock
    input  wire logic        core_clk,
    // data input half writes
    output logic             dataWrite,
    output logic             dataHighHalf,
    output logic [1:0]       dataByteEn,
    output logic [15:0]      dataWdata,
    // go strobes
    output logic             goSet,
    output logic             goClear,
    // result preload
    output logic             resultWrite,
    output logic [31:0]      resultWdata
);
    // idle values at time zero
    initial
    begin
        dataWrite    = 1'b0;
        dataHighHalf = 1'b0;
        dataByteEn   = 2'h0;
        dataWdata    = 16'h0000;
        goSet        = 1'b0;
        goClear      = 1'b0;
        resultWrite  = 1'b0;
        resultWdata  = 32'h0000_0000;
    end

    // one-cycle write; data inverted afterwards so stale values never match
    task automatic write_half(input logic hi, input logic [1:0] en, input logic [15:0] d);
        @(posedge core_clk);
        dataWrite    <= 1'b1;
        dataHighHalf <= hi;
        dataByteEn   <= en;
        dataWdata    <= d;
        @(posedge core_clk);
        dataWrite    <= 1'b0;
        dataWdata    <= ~d;
    endtask

    // whole word in byte units, full bytes even for narrow words
    task automatic write_word(input logic [31:0] w, input int width);
        write_half(1'b0, (width > 8) ? 2'h3 : 2'h1, w[15:0]);
        if (width > 16)
            write_half(1'b1, (width > 24) ? 2'h3 : 2'h1, w[31:16]);
    endtask

    // set or software clear of go
    task automatic strobe_go(input logic setGo);
        @(posedge core_clk);
        goSet   <= setGo;
        goClear <= ~setGo;
        @(posedge core_clk);
        goSet   <= 1'b0;
        goClear <= 1'b0;
    endtask

    // checksum preload
    task automatic preload(input logic [31:0] v);
        @(posedge core_clk);
        resultWrite <= 1'b1;
        resultWdata <= v;
        @(posedge core_clk);
        resultWrite <= 1'b0;
        resultWdata <= ~v;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_programmable_crc_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_programmable_crc_engine;
    import crc_pkg::*;
    // clock, reset and configuration levels
    logic core_clk, arst_n, moduleEnable, lsbFirstSelect, irqSourceSelect;
    logic [4:0]  polyLenField, wordWidthField;
    logic [15:0] polyTermsLow, polyTermsHigh;
    // core model outputs
    logic dataWrite, dataHighHalf, goSet, goClear, resultWrite;
    logic [1:0]  dataByteEn;
    logic [15:0] dataWdata;
    logic [31:0] resultWdata;
    // status outputs
    logic shiftGo, fifoFullFlag, fifoEmptyFlag, crcIrq;
    logic [4:0]  validWordCount;
    logic [31:0] resultPair;
    // bookkeeping
    int n_mismatch, check_count, irqSeen;
    // band table: wide, mid and narrow word widths
    // mid band uses an odd width so the one-bit tail step is exercised
    logic [4:0] wfTab[3]    = '{5'h1F, 5'h0C, 5'h05};
    logic [4:0] depthTab[3] = '{5'h04, 5'h08, 5'h10};
    logic [4:0] lenTab[3]   = '{5'h1F, 5'h0F, 5'h07};
    logic       lsbTab[3]   = '{1'b0, 1'b1, 1'b0};
    logic       iselTab[3]  = '{1'b1, 1'b0, 1'b1};

    programmable_crc_engine i_dut (.core_clk(core_clk), .arst_n(arst_n), .moduleEnable(moduleEnable),
        .lsbFirstSelect(lsbFirstSelect), .irqSourceSelect(irqSourceSelect), .polyLenField(polyLenField),
        .wordWidthField(wordWidthField), .polyTermsLow(polyTermsLow), .polyTermsHigh(polyTermsHigh),
        .dataWrite(dataWrite), .dataHighHalf(dataHighHalf), .dataByteEn(dataByteEn), .dataWdata(dataWdata),
        .goSet(goSet), .goClear(goClear), .resultWrite(resultWrite), .resultWdata(resultWdata),
        .shiftGo(shiftGo), .validWordCount(validWordCount), .fifoFullFlag(fifoFullFlag),
        .fifoEmptyFlag(fifoEmptyFlag), .resultPair(resultPair), .crcIrq(crcIrq));
    crc_core_model i_core (.core_clk(core_clk), .dataWrite(dataWrite), .dataHighHalf(dataHighHalf),
        .dataByteEn(dataByteEn), .dataWdata(dataWdata), .goSet(goSet), .goClear(goClear),
        .resultWrite(resultWrite), .resultWdata(resultWdata));

    // 40 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // event pulses counted where settled
    always @(negedge core_clk)
        if (crcIrq === 1'b1)
            irqSeen++;

    // mask of the active shift register width
    function automatic logic [31:0] len_mask(input logic [4:0] len);
        return (len == 5'h1F) ? 32'hFFFF_FFFF : ((32'h1 << (len + 1)) - 32'h1);
    endfunction

    // bit-serial reference: feedback from top stage, constant term forced, top term implicit
    function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [31:0] w, input int width,
                                            input logic [4:0] len, input logic lsb);
        logic [31:0] p;
        logic        fb;
        int          k;
        p = ({polyTermsHigh, polyTermsLow} | 32'h1) & len_mask(len);
        for (int i = 0; i < width; i++)
        begin
            k  = lsb ? i : width - 1 - i;
            fb = c[len] ^ w[k];
            c  = (c << 1) & len_mask(len);
            if (fb)
                c = c ^ p;
        end
        return c;
    endfunction

    // test word, upper bits deliberately busy
    function automatic logic [31:0] word_of(input int b, input int j);
        return 32'h9E37_79B9 * (j + 3 * b + 1);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // bounded wait for go to rise and drop again
    task automatic wait_done();
        bit started;
        int k;
        started = 1'b0;
        for (k = 0; k < 600; k++)
        begin
            @(negedge core_clk);
            if (shiftGo === 1'b1)
                started = 1'b1;
            else if (started)
                break;
        end
        if (k == 600)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, shiftGo, 1'b0);
            print_verdict();
        end
    endtask

    // main sequence
    initial
    begin
        logic [31:0] exp;
        int          width;
        n_mismatch = 0;
        check_count = 0;
        irqSeen = 0;
        arst_n = 1'b0;
        moduleEnable = 1'b0;
        lsbFirstSelect = 1'b0;
        irqSourceSelect = 1'b0;
        polyLenField = 5'h00;
        wordWidthField = 5'h00;
        polyTermsLow = 16'h0000;
        polyTermsHigh = 16'h0000;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        check({shiftGo, fifoFullFlag, fifoEmptyFlag, validWordCount}, 32'h0000_0020);
        check(resultPair, 32'h0000_0000);
        // bit zero set on purpose: must make no difference
        @(posedge core_clk);
        polyTermsHigh <= 16'h04C1;
        polyTermsLow  <= 16'h1DB7;
        moduleEnable  <= 1'b1;
        irqSourceSelect <= 1'b1;
        // go with nothing queued, then software clear: no event
        i_core.strobe_go(1'b1);
        i_core.strobe_go(1'b0);
        @(negedge core_clk);
        check({shiftGo, irqSeen[3:0]}, 32'h0);
        // low half of a wide word alone is not counted
        @(posedge core_clk);
        wordWidthField <= 5'h1F;
        i_core.write_half(1'b0, 2'h3, 16'hBEEF);
        @(negedge core_clk);
        check(validWordCount, 32'h0);
        i_core.write_half(1'b1, 2'h3, 16'hCAFE);
        @(negedge core_clk);
        check(validWordCount, 32'h1);
        for (int b = 0; b < 3; b++)
        begin
            width = wfTab[b] + 1;
            @(posedge core_clk);
            lsbFirstSelect  <= lsbTab[b];
            irqSourceSelect <= iselTab[b];
            polyLenField    <= lenTab[b];
            wordWidthField  <= wfTab[b];
            // one word past the depth: words that find the fifo full are dropped
            for (int j = 0; j <= depthTab[b]; j++)
                i_core.write_word(word_of(b, j), width);
            @(negedge core_clk);
            check({fifoFullFlag, validWordCount}, {26'h0, 1'b1, depthTab[b]});
            // disabling flushes the fifo
            @(posedge core_clk);
            moduleEnable <= 1'b0;
            @(posedge core_clk);
            moduleEnable <= 1'b1;
            @(negedge core_clk);
            check({fifoFullFlag, fifoEmptyFlag, validWordCount}, 32'h20);
            // preload all ones: only the active width keeps them
            i_core.preload(32'hFFFF_FFFF);
            @(negedge core_clk);
            check(resultPair, len_mask(lenTab[b]));
            check(validWordCount, 32'h0);
            for (int j = 0; j < depthTab[b]; j++)
                i_core.write_word(word_of(b, j), width);
            @(negedge core_clk);
            check({fifoFullFlag, validWordCount}, {26'h0, 1'b1, depthTab[b]});
            exp = len_mask(lenTab[b]);
            for (int j = 0; j < depthTab[b]; j++)
                exp = ref_crc(exp, word_of(b, j), width, lenTab[b], lsbTab[b]);
            irqSeen = 0;
            i_core.strobe_go(1'b1);
            wait_done();
            // one more edge so the event counter has seen the final pulse
            @(negedge core_clk);
            check(resultPair, exp);
            check({fifoEmptyFlag, validWordCount}, 32'h20);
            check(irqSeen, 32'h1);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
